// file: src/iolcs_pkg.sv
// constants for the i/o link connection sequencer
package iolcs_pkg;
  // ----------------------------------------------------------------
  // link word layout
  // ----------------------------------------------------------------
  localparam int LINK_DATA_W = 16;
  localparam int LINK_WORD_W = 17;
  localparam int RET_W       = 4;
  localparam int PAR_BIT     = 16;
  // ----------------------------------------------------------------
  // internal word 4 fields
  // ----------------------------------------------------------------
  localparam int W4_PORT_LSB = 16;
  localparam int W4_PORT_W   = 4;
  localparam int W4_BCC_BIT  = 15;
  localparam int W4_LEM_BIT  = 14;
  localparam int W4_BASE_LSB = 4;
  localparam int W4_ADPT_LSB = 0;
  localparam int W4_W        = 20;
  // ----------------------------------------------------------------
  // control block word offsets and widths
  // ----------------------------------------------------------------
  localparam int MEM_AW      = 24;
  localparam int MEM_DW      = 48;
  localparam logic [MEM_AW-1:0] CB_ADDR_WORD = 24'h000001;
  localparam logic [MEM_AW-1:0] CB_CMD_PTR   = 24'h000004;
  localparam int HOST_W      = 8;
  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_STATUS   = 8'h00;
  localparam logic [REG_AW-1:0] REG_DESC_LEN = 8'h04;
  localparam logic [REG_AW-1:0] REG_HOST_ID  = 8'h08;
  localparam logic [REG_AW-1:0] REG_PORT_EN  = 8'h0C;
  localparam logic [REG_AW-1:0] REG_WORD4    = 8'h10;
  localparam logic [REG_AW-1:0] REG_LINK_IN  = 8'h14;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_ERR_BIT  = 1;
  localparam int ST_BUSY_BIT = 2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  DESC_LEN_RST = 8'h01;
  localparam logic [7:0]  HOST_ID_RST  = 8'h00;
  localparam logic [7:0]  PORT_EN_RST  = 8'hFF;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IOLCS_IDLE    = 4'h0,
    IOLCS_RD_W1   = 4'h1,
    IOLCS_RD_W4   = 4'h2,
    IOLCS_BUILD   = 4'h3,
    IOLCS_RD_DESC = 4'h4,
    IOLCS_STROBE  = 4'h5,
    IOLCS_RELEASE = 4'h6,
    IOLCS_NEXT    = 4'h7
  } iolcs_state_e;
  // word kinds in a connection sequence, in send order
  typedef enum logic [2:0] {
    IOLCS_W_ADDR  = 3'h0,
    IOLCS_W_DESC  = 3'h1,
    IOLCS_W_LPW1  = 3'h2,
    IOLCS_W_LINK1 = 3'h3,
    IOLCS_W_LINK2 = 3'h4,
    IOLCS_W_LPW2  = 3'h5
  } iolcs_word_e;
endpackage

// file: src/iolcs_sequencer.sv
// connection sequencer of the host link processor
//
// What this block does
// - words are 16 data bits plus odd parity
// - each side owns one strobe line
// - two sync lines between both sides
// - sequence sends at least six control words
// - first word is the address word
// - block parity word follows descriptor words
// - then two descriptor link words
// - final parity over the preceding three words
// - start-i/o operator with control block address starts
// - port from word 4 bits 19..16
// - address word holds card and expansion bits
// - address word holds base and adapter ids
// - parity bit makes ones count odd
// - descriptors fetched via command pointer, 16-bit words
// - first parity covers only descriptor words
// - link words built from words 7 and A
// - link word 1: host byte then address byte
// - one to eight link ports
// - each cable addresses up to sixteen bases
// - parity word ends every burst
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module iolcs_sequencer #(
  parameter int NPORT = 8
) (
  input  wire logic                                  clock,
  input  wire logic                                  reset_n,
  // start-i/o operator
  input  wire logic                                  start_io,
  input  wire logic [iolcs_pkg::MEM_AW-1:0]          start_cb_addr,
  output logic                                       start_busy,
  // system memory read port
  output logic                                       mem_rd_req,
  output logic [iolcs_pkg::MEM_AW-1:0]               mem_rd_addr,
  input  wire logic                                  mem_rd_ack,
  input  wire logic [iolcs_pkg::MEM_DW-1:0]          mem_rd_data,
  // register port
  input  wire logic [iolcs_pkg::REG_AW-1:0]          reg_addr,
  input  wire logic [31:0]                           reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic [31:0]                                reg_rdata,
  // link cables, one slice per port
  output logic [NPORT*iolcs_pkg::LINK_WORD_W-1:0]    link_data_o,
  output logic [NPORT-1:0]                           link_data_oe,
  input  wire logic [NPORT*iolcs_pkg::LINK_WORD_W-1:0] link_data_i,
  input  wire logic [NPORT*iolcs_pkg::RET_W-1:0]     link_ret_i,
  output logic [NPORT-1:0]                           link_host_strobe,
  input  wire logic [NPORT-1:0]                      link_peer_strobe,
  output logic [NPORT-1:0]                           link_sync_o,
  input  wire logic [NPORT-1:0]                      link_sync_i
);
  import iolcs_pkg::*;

  localparam int PW = (NPORT > 1) ? $clog2(NPORT) : 1;
  localparam int LW = LINK_WORD_W;

  iolcs_state_e state_r;
  iolcs_word_e  kind_r;
  logic [W4_W-1:0]        word4_r;
  logic [MEM_AW-1:0]      word7_r;
  logic [HOST_W-1:0]      worda_r;
  logic [MEM_AW-1:0]      cmd_ptr_r;
  logic [7:0]             desc_cnt_r;
  logic [7:0]             desc_len_r;
  logic [7:0]             port_en_r;
  logic [LINK_DATA_W-1:0] data_nxt;
  logic [LINK_DATA_W-1:0] lpw_r;
  logic [LINK_WORD_W-1:0] out_r;
  logic                   drive_r;
  logic                   strobe_r;
  logic [W4_PORT_W-1:0]   port_r;
  logic                   done_r;
  logic                   err_r;
  logic [NPORT-1:0]       peer_s1_r;
  logic [NPORT-1:0]       peer_s2_r;
  logic [NPORT-1:0]       sync_s1_r;
  logic [NPORT-1:0]       sync_s2_r;
  logic [NPORT*RET_W-1:0] ret_s1_r;
  logic [NPORT*RET_W-1:0] ret_s2_r;
  logic [NPORT*LW-1:0]    din_s1_r;
  logic [NPORT*LW-1:0]    din_s2_r;
  logic [LW-1:0]          rx_word_r;
  logic [RET_W-1:0]       ret_sel;
  logic                   peer_sel;
  logic                   sync_sel;
  logic [PW-1:0]          psel;
  logic                   port_ok;
  logic                   done_clr;
  logic                   err_clr;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      peer_s1_r <= '0;
      peer_s2_r <= '0;
      sync_s1_r <= '0;
      sync_s2_r <= '0;
      ret_s1_r  <= '0;
      ret_s2_r  <= '0;
      din_s1_r  <= '0;
      din_s2_r  <= '0;
    end else begin
      peer_s1_r <= link_peer_strobe;
      peer_s2_r <= peer_s1_r;
      sync_s1_r <= link_sync_i;
      sync_s2_r <= sync_s1_r;
      ret_s1_r  <= link_ret_i;
      ret_s2_r  <= ret_s1_r;
      din_s1_r  <= link_data_i;
      din_s2_r  <= din_s1_r;
    end
  end

  assign psel     = port_r[PW-1:0];
  assign peer_sel = peer_s2_r[psel];
  assign sync_sel = sync_s2_r[psel];
  assign ret_sel  = ret_s2_r[psel*RET_W +: RET_W];

  // port chosen must exist and be enabled
  assign port_ok = ({1'b0, mem_rd_data[W4_PORT_LSB +: W4_PORT_W]} < 5'(NPORT))
                 && port_en_r[mem_rd_data[W4_PORT_LSB +: 3]];

  // ----------------------------------------------------------------
  // per-port cable drivers
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      assign link_data_o[gp*LW +: LW] = (drive_r && psel == PW'(gp)) ? out_r : '0;
      assign link_data_oe[gp]     = drive_r && psel == PW'(gp);
      assign link_host_strobe[gp] = strobe_r && psel == PW'(gp);
      assign link_sync_o[gp]      = drive_r && psel == PW'(gp);
    end
  endgenerate

  // ----------------------------------------------------------------
  // next link word
  // ----------------------------------------------------------------
  always_comb begin
    data_nxt = '0;
    unique case (kind_r)
      IOLCS_W_ADDR: begin
        data_nxt[15] = word4_r[W4_BCC_BIT];
        data_nxt[14] = word4_r[W4_LEM_BIT];
        data_nxt[7:4] = word4_r[W4_BASE_LSB +: 4];
        data_nxt[3:0] = word4_r[W4_ADPT_LSB +: 4];
      end
      IOLCS_W_DESC:  data_nxt = mem_rd_data[LINK_DATA_W-1:0];
      IOLCS_W_LPW1:  data_nxt = lpw_r;
      IOLCS_W_LINK1: data_nxt = {worda_r, word7_r[23:16]};
      IOLCS_W_LINK2: data_nxt = word7_r[15:0];
      IOLCS_W_LPW2:  data_nxt = lpw_r;
      default:       data_nxt = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_r    <= IOLCS_IDLE;
      kind_r     <= IOLCS_W_ADDR;
      word4_r    <= '0;
      word7_r    <= '0;
      cmd_ptr_r  <= '0;
      desc_cnt_r <= '0;
      lpw_r      <= '0;
      out_r      <= '0;
      drive_r    <= 1'b0;
      port_r     <= '0;
    end else begin
      unique case (state_r)
        IOLCS_IDLE: begin
          if (start_io) begin
            word7_r <= start_cb_addr;
            state_r <= IOLCS_RD_W1;
          end
        end
        IOLCS_RD_W1: begin
          if (mem_rd_ack) begin
            word4_r <= mem_rd_data[W4_W-1:0];
            port_r  <= mem_rd_data[W4_PORT_LSB +: W4_PORT_W];
            state_r <= port_ok ? IOLCS_RD_W4 : IOLCS_IDLE;
          end
        end
        IOLCS_RD_W4: begin
          if (mem_rd_ack) begin
            cmd_ptr_r  <= mem_rd_data[MEM_AW-1:0];
            desc_cnt_r <= '0;
            kind_r     <= IOLCS_W_ADDR;
            state_r    <= IOLCS_BUILD;
          end
        end
        IOLCS_RD_DESC: begin
          if (mem_rd_ack) begin
            lpw_r   <= lpw_r ^ data_nxt;
            out_r   <= {~^data_nxt, data_nxt};
            drive_r <= 1'b1;
            state_r <= IOLCS_STROBE;
          end
        end
        IOLCS_BUILD: begin
          if (kind_r == IOLCS_W_DESC) begin
            state_r <= IOLCS_RD_DESC;
          end else begin
            out_r   <= {~^data_nxt, data_nxt};
            drive_r <= 1'b1;
            state_r <= IOLCS_STROBE;
            if (kind_r == IOLCS_W_ADDR || kind_r == IOLCS_W_LPW1) begin
              lpw_r <= (kind_r == IOLCS_W_LPW1) ? data_nxt : '0;
            end else begin
              lpw_r <= lpw_r ^ data_nxt;
            end
          end
        end
        IOLCS_STROBE: begin
          // hold strobe until the peer answers with its own
          if (strobe_r && peer_sel) begin
            state_r <= IOLCS_RELEASE;
          end
        end
        IOLCS_RELEASE: begin
          if (!peer_sel) begin
            state_r <= IOLCS_NEXT;
          end
        end
        IOLCS_NEXT: begin
          state_r <= IOLCS_BUILD;
          unique case (kind_r)
            IOLCS_W_ADDR:  kind_r <= IOLCS_W_DESC;
            IOLCS_W_DESC: begin
              desc_cnt_r <= desc_cnt_r + 8'h01;
              if (desc_cnt_r + 8'h01 >= desc_len_r) begin
                kind_r <= IOLCS_W_LPW1;
              end
            end
            IOLCS_W_LPW1:  kind_r <= IOLCS_W_LINK1;
            IOLCS_W_LINK1: kind_r <= IOLCS_W_LINK2;
            IOLCS_W_LINK2: kind_r <= IOLCS_W_LPW2;
            IOLCS_W_LPW2: begin
              drive_r <= 1'b0;
              state_r <= IOLCS_IDLE;
            end
            default:       kind_r <= IOLCS_W_ADDR;
          endcase
        end
        default: state_r <= IOLCS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // cable strobe and read-back
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      strobe_r <= 1'b0;
    end else begin
      strobe_r <= (state_r == IOLCS_STROBE) && !(strobe_r && peer_sel);
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rx_word_r <= '0;
    end else if (state_r == IOLCS_STROBE && strobe_r && peer_sel) begin
      rx_word_r <= din_s2_r[psel*LW +: LW];
    end
  end

  // memory read requests
  always_comb begin
    mem_rd_req  = 1'b0;
    mem_rd_addr = '0;
    unique case (state_r)
      IOLCS_RD_W1: begin
        mem_rd_req  = 1'b1;
        mem_rd_addr = word7_r + CB_ADDR_WORD;
      end
      IOLCS_RD_W4: begin
        mem_rd_req  = 1'b1;
        mem_rd_addr = word7_r + CB_CMD_PTR;
      end
      IOLCS_RD_DESC: begin
        mem_rd_req  = 1'b1;
        mem_rd_addr = cmd_ptr_r + {16'h0000, desc_cnt_r};
      end
      default: begin
        mem_rd_req  = 1'b0;
        mem_rd_addr = '0;
      end
    endcase
  end

  assign start_busy = (state_r != IOLCS_IDLE);

  // ----------------------------------------------------------------
  // status flags: hardware set wins over software clear
  // ----------------------------------------------------------------
  assign done_clr = reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_DONE_BIT];
  assign err_clr  = reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_ERR_BIT];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      done_r <= 1'b0;
    end else if (state_r == IOLCS_NEXT && kind_r == IOLCS_W_LPW2) begin
      done_r <= 1'b1;
    end else if (done_clr) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      err_r <= 1'b0;
    end else if (state_r == IOLCS_RD_W1 && mem_rd_ack && !port_ok) begin
      err_r <= 1'b1;
    end else if (err_clr) begin
      err_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      desc_len_r <= DESC_LEN_RST;
      worda_r    <= HOST_ID_RST;
      port_en_r  <= PORT_EN_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_DESC_LEN && reg_wdata[7:0] != 8'h00) begin
        desc_len_r <= reg_wdata[7:0];
      end
      if (reg_addr == REG_HOST_ID) begin
        worda_r <= reg_wdata[HOST_W-1:0];
      end
      if (reg_addr == REG_PORT_EN) begin
        port_en_r <= reg_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS:   reg_rdata <= {20'h00000, sync_sel, port_r, state_r,
                                    start_busy, err_r, done_r};
        REG_DESC_LEN: reg_rdata <= {24'h000000, desc_len_r};
        REG_HOST_ID:  reg_rdata <= {24'h000000, worda_r};
        REG_PORT_EN:  reg_rdata <= {24'h000000, port_en_r};
        REG_WORD4:    reg_rdata <= {12'h000, word4_r};
        REG_LINK_IN:  reg_rdata <= {11'h000, ret_sel, rx_word_r};
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

// file: tb/io_link_connection_sequencer_test.sv
// self-checking bench for the connection sequencer
`timescale 1ns/1ps
module io_link_connection_sequencer_test;
  import iolcs_pkg::*;
  localparam int NP = 2;
  localparam logic [23:0] CB  = 24'h123450;
  localparam logic [23:0] CMD = 24'h000800;
  logic clock = 1'b0, reset_n = 1'b0, start_io = 1'b0, slow = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, mem_rd_ack = 1'b0, start_busy, mem_rd_req, rx_stb;
  logic [23:0] start_cb_addr = 24'h0, mem_rd_addr;
  logic [47:0] mem_rd_data = 48'h0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [NP*17-1:0] do_w, di_w;
  logic [NP*4-1:0] ret_w;
  logic [NP-1:0] oe_w, hs_w, ps_w, so_w, si_w;
  logic [16:0] rx_word;
  logic [3:0] rx_port;
  logic [19:0] w1 = 20'h0;
  logic [16:0] rxq[$];
  logic [3:0] rxp[$];
  int errors = 0, n_compared = 0;
  always #4 clock = ~clock;
  iolcs_sequencer #(.NPORT(NP)) DUT (.clock, .reset_n, .start_io, .start_cb_addr, .start_busy,
    .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_rd_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .link_data_o(do_w), .link_data_oe(oe_w), .link_data_i(di_w), .link_ret_i(ret_w),
    .link_host_strobe(hs_w), .link_peer_strobe(ps_w), .link_sync_o(so_w), .link_sync_i(si_w));
  iolcs_peer #(.NPORT(NP)) u_peer (.clock, .reset_n, .slow, .link_data_o(do_w),
    .link_data_oe(oe_w), .link_host_strobe(hs_w), .link_sync_o(so_w), .link_data_i(di_w),
    .link_ret_i(ret_w), .link_peer_strobe(ps_w), .link_sync_i(si_w), .rx_stb, .rx_word, .rx_port);
  function automatic logic [47:0] mem_word(input logic [23:0] a);
    if (a == CB + 24'h000001) return {28'h0, w1};
    if (a == CB + 24'h000004) return {24'h0, CMD};
    return {32'h0, a[15:0] ^ 16'hC3A5};
  endfunction
  always @(posedge clock) begin
    mem_rd_ack <= mem_rd_req && !mem_rd_ack;
    mem_rd_data <= mem_word(mem_rd_addr);
    if (rx_stb === 1'b1) begin
      rxq.push_back(rx_word);
      rxp.push_back(rx_port);
    end
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock) reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock) reg_rd <= 1'b0;
    @(negedge clock) d = reg_rdata;
    @(posedge clock);
  endtask
  // start, poke a second start while busy, wait for the end
  task automatic conn(input logic [19:0] w);
    int i;
    w1 = w;
    rxq.delete();
    rxp.delete();
    start_io <= 1'b1;
    start_cb_addr <= CB;
    @(posedge clock) start_io <= 1'b0;
    @(posedge clock) start_io <= 1'b1;
    @(posedge clock) start_io <= 1'b0;
    for (i = 0; i < 3000 && start_busy !== 1'b0; i++) @(negedge clock);
    chk(start_busy, 1'b0);
    @(posedge clock);
  endtask
  task automatic expect_seq(input logic [19:0] w, input int n, input logic [7:0] h, input int pt);
    logic [15:0] e[$];
    logic [15:0] l1;
    int k;
    l1 = 16'h0;
    e.push_back({w[15], w[14], 6'h00, w[7:4], w[3:0]});
    for (k = 0; k < n; k++) begin
      e.push_back((CMD[15:0] + k[15:0]) ^ 16'hC3A5);
      l1 ^= e[k+1];
    end
    e.push_back(l1);
    e.push_back({h, CB[23:16]});
    e.push_back(CB[15:0]);
    e.push_back(l1 ^ e[n+2] ^ e[n+3]);
    chk(rxq.size(), e.size());
    for (k = 0; k < e.size() && k < rxq.size(); k++) begin
      chk(rxq[k], {~^e[k], e[k]});
      chk(rxp[k], pt);
    end
    rd(REG_LINK_IN);
    chk(d, {11'h000, 4'h6, ~^e[n+4], e[n+4]});
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(REG_STATUS);
    chk(d, 32'h0);
    rd(REG_DESC_LEN);
    chk(d, 32'h1);
    rd(REG_HOST_ID);
    chk(d, 32'h0);
    rd(REG_PORT_EN);
    chk(d, 32'hFF);
    rd(8'h18);
    chk(d, 32'h0);
    wr(REG_DESC_LEN, 32'h0);
    rd(REG_DESC_LEN);
    chk(d, 32'h1);
    $display("test registers done");
    wr(REG_DESC_LEN, 32'h3);
    wr(REG_HOST_ID, 32'h5A);
    conn(20'h1BF5A);
    expect_seq(20'h1BF5A, 3, 8'h5A, 1);
    rd(REG_WORD4);
    chk(d, 32'h1BF5A);
    rd(REG_STATUS);
    chk(d & 32'h7, 32'h1);
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS);
    chk(d & 32'h7, 32'h0);
    $display("test prompt sequence done");
    slow <= 1'b1;
    wr(REG_DESC_LEN, 32'h1);
    conn(20'h0403C);
    expect_seq(20'h0403C, 1, 8'h5A, 0);
    slow <= 1'b0;
    $display("test slow sequence done");
    conn(20'h2805A);
    chk(rxq.size(), 0);
    rd(REG_STATUS);
    chk(d & 32'h3, 32'h3);
    wr(REG_STATUS, 32'h3);
    wr(REG_PORT_EN, 32'h1);
    conn(20'h1805A);
    chk(rxq.size(), 0);
    rd(REG_STATUS);
    chk(d & 32'h3, 32'h2);
    $display("test refused starts done");
    print_verdict();
  end
endmodule

// file: tb/iolcs_assertions.sv
// port checker for the connection sequencer
`timescale 1ns/1ps
module iolcs_checker #(
  parameter int NPORT = 8
) (
  input wire logic                                   clock,
  input wire logic                                   reset_n,
  input wire logic                                   start_io,
  input wire logic [iolcs_pkg::MEM_AW-1:0]           start_cb_addr,
  input wire logic                                   start_busy,
  input wire logic                                   mem_rd_req,
  input wire logic [iolcs_pkg::MEM_AW-1:0]           mem_rd_addr,
  input wire logic                                   mem_rd_ack,
  input wire logic                                   reg_rd,
  input wire logic [31:0]                            reg_rdata,
  input wire logic [NPORT*iolcs_pkg::LINK_WORD_W-1:0] link_data_o,
  input wire logic [NPORT-1:0]                       link_data_oe,
  input wire logic [NPORT-1:0]                       link_host_strobe,
  input wire logic [NPORT-1:0]                       link_peer_strobe,
  input wire logic [NPORT-1:0]                       link_sync_o
);
  import iolcs_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // start, memory, register read data and sync level
  // ----------------------------------------------------------------
  sequence s_take;
    start_io && !start_busy;
  endsequence
  sequence s_first;
    mem_rd_req && mem_rd_addr == $past(start_cb_addr) + 24'h000001;
  endsequence
  a_start_busy: assert property (s_take |=> start_busy)
    else $error("busy not raised after start");
  a_first_read: assert property (s_take |=> s_first)
    else $error("first read not at block word 1");
  a_req_hold: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("read request dropped or moved");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read answer");
  a_sync_level: assert property (link_sync_o == link_data_oe)
    else $error("sync level differs from drive enable");
  // ----------------------------------------------------------------
  // per cable
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    a_odd_parity: assert property (link_data_oe[p] |-> ^link_data_o[p*LINK_WORD_W+:LINK_WORD_W])
      else $error("even parity on link word");
    a_idle_zero: assert property (!link_data_oe[p] |-> link_data_o[p*LINK_WORD_W+:LINK_WORD_W] == 17'h0)
      else $error("data on unselected cable");
    a_strobe_oe: assert property (link_host_strobe[p] |-> link_data_oe[p])
      else $error("strobe without drive");
    a_strobe_hold: assert property (link_host_strobe[p] && !link_peer_strobe[p] |=> link_host_strobe[p])
      else $error("strobe dropped before peer answer");
    a_strobe_drop: assert property ($rose(link_peer_strobe[p]) |-> ##[1:5] !link_host_strobe[p])
      else $error("strobe not released");
    a_word_stable: assert property (link_host_strobe[p] |-> $stable(link_data_o[p*LINK_WORD_W+:LINK_WORD_W]))
      else $error("word changed under strobe");
  end
endmodule

bind iolcs_sequencer iolcs_checker #(.NPORT(NPORT)) u_chk (.clock, .reset_n, .start_io,
  .start_cb_addr, .start_busy, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .reg_rd, .reg_rdata,
  .link_data_o, .link_data_oe, .link_host_strobe, .link_peer_strobe, .link_sync_o);

// file: tb/iolcs_peer.sv
// peripheral cabinet model on the far end of the cables
`timescale 1ns/1ps
module iolcs_peer #(
  parameter int NPORT = 2
) (
  input wire logic                                   clock,
  input wire logic                                   reset_n,
  input wire logic                                   slow,
  input wire logic [NPORT*iolcs_pkg::LINK_WORD_W-1:0] link_data_o,
  input wire logic [NPORT-1:0]                       link_data_oe,
  input wire logic [NPORT-1:0]                       link_host_strobe,
  input wire logic [NPORT-1:0]                       link_sync_o,
  output logic [NPORT*iolcs_pkg::LINK_WORD_W-1:0]    link_data_i,
  output logic [NPORT*iolcs_pkg::RET_W-1:0]          link_ret_i,
  output logic [NPORT-1:0]                           link_peer_strobe,
  output logic [NPORT-1:0]                           link_sync_i,
  output logic                                       rx_stb,
  output logic [16:0]                                rx_word,
  output logic [3:0]                                 rx_port
);
  import iolcs_pkg::*;
  logic [NPORT-1:0]             hs_q;
  logic [NPORT*LINK_WORD_W-1:0] last_q;
  int                           cnt [NPORT];
  assign link_ret_i = {NPORT{4'h6}};
  // released pins toggle so no stale value survives
  for (genvar p = 0; p < NPORT; p++) begin : g_pin
    assign link_data_i[p*LINK_WORD_W+:LINK_WORD_W] = link_data_oe[p] ?
      link_data_o[p*LINK_WORD_W+:LINK_WORD_W] : ~last_q[p*LINK_WORD_W+:LINK_WORD_W];
  end
  always_ff @(posedge clock) begin
    rx_stb <= 1'b0;
    last_q <= reset_n ? link_data_i : '0;
    link_sync_i <= reset_n ? link_sync_o : '0;
    for (int p = 0; p < NPORT; p++) begin
      hs_q[p] <= link_host_strobe[p];
      // keep every word taken, link words included
      if (link_host_strobe[p] && !hs_q[p]) begin
        rx_stb <= 1'b1;
        rx_word <= link_data_o[p*LINK_WORD_W+:LINK_WORD_W];
        rx_port <= p[3:0];
      end
      cnt[p] <= (link_peer_strobe[p] != link_host_strobe[p]) ? cnt[p] + 1 : 0;
      if (!reset_n) begin
        link_peer_strobe[p] <= 1'b0;
        cnt[p] <= 0;
      end else if (cnt[p] >= (slow ? 6 : 1)) begin
        link_peer_strobe[p] <= link_host_strobe[p];
      end
    end
  end
endmodule
